// ===== verilog/bdp_ctrl.sv
// Top: DMA idle insertion, secondary clock pin and memory pin drive control
module bdp_ctrl (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              cfg_wr,
    input  wire logic [7:0]        cfg_wdata,
    output logic      [7:0]        cfg_rdata,
    input  wire logic              req_valid,
    input  wire bdp_pkg::bdp_req_t req,
    output logic                   req_ready,
    input  wire logic              acc_done,
    output logic                   idle_active,
    input  wire logic [2:0]        clock_mode,
    output logic                   secondary_clock_pin_o,
    output logic                   secondary_clock_pin_oe,
    input  wire logic              sw_standby,
    output logic                   mem_pins_oe
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************************************
    // Control word
    // ****************************************************************
    bdp_pkg::bdp_cfg_t cfg;
    bdp_pkg::bdp_cfg_t wr_cfg;
    bdp_pkg::bdp_cfg_t next_cfg;

    // Reserved bits are forced, so a careless write cannot flip them
    assign wr_cfg = '{
        dma_idle_count:         cfg_wdata[7:5],
        dma_idle_insert_method: cfg_wdata[4],
        rsv_one:                bdp_pkg::RSV_ONE_VAL,
        rsv_zero:               bdp_pkg::RSV_ZERO_VAL,
        secondary_clock_drive:  cfg_wdata[1],
        memory_pins_float_ctrl: cfg_wdata[0]
    };
    assign next_cfg = cfg_wr ? wr_cfg : cfg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= bdp_pkg::CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    assign cfg_rdata = cfg;

    // ****************************************************************
    // Idle insertion
    // ****************************************************************
    bdp_pkg::bdp_state_t state;
    bdp_pkg::bdp_state_t next_state;
    bdp_pkg::bdp_req_t   cur;
    bdp_pkg::bdp_req_t   last_dev;
    logic                pending;
    logic                next_pending;
    logic                timer_last;

    wire [3:0] idle_len   = bdp_pkg::bdp_idle_cycles(cfg.dma_idle_count);
    wire       method_all = cfg.dma_idle_insert_method;
    wire       same_dev   = req.dma_acknowledge && (req.chan == last_dev.chan);
    wire       in_ready   = (state == bdp_pkg::ST_READY);
    // A different driver takes the bus after an acknowledged device
    wire       handover   = in_ready && req_valid && pending && !same_dev;
    wire       do_idle_m0 = handover && !method_all && (idle_len != 4'h0);
    wire       done_dma_acknowledge  = (state == bdp_pkg::ST_ACCESS) && acc_done && cur.dma_acknowledge;
    wire       do_idle_m1 = done_dma_acknowledge && method_all && (idle_len != 4'h0);
    wire       taken      = in_ready && req_valid && req_ready;
    wire       load_timer = do_idle_m0 || do_idle_m1;

    // Same device keeping the bus passes straight through under method 0
    assign req_ready   = in_ready && !do_idle_m0;
    assign idle_active = (state == bdp_pkg::ST_IDLE);

    always_comb begin
        next_state = state;
        case (state)
            bdp_pkg::ST_READY: begin
                if (do_idle_m0) begin
                    next_state = bdp_pkg::ST_IDLE;
                end else if (taken) begin
                    next_state = bdp_pkg::ST_ACCESS;
                end
            end
            bdp_pkg::ST_ACCESS: begin
                if (do_idle_m1) begin
                    next_state = bdp_pkg::ST_IDLE;
                end else if (acc_done) begin
                    next_state = bdp_pkg::ST_READY;
                end
            end
            bdp_pkg::ST_IDLE: begin
                if (timer_last) begin
                    next_state = bdp_pkg::ST_READY;
                end
            end
            default: next_state = bdp_pkg::ST_READY;
        endcase
    end

    // Under method 0, pending marks that an acknowledged device was the last bus driver
    always_comb begin
        next_pending = pending;
        if (done_dma_acknowledge && !method_all) begin
            next_pending = 1'b1;
        end else if (load_timer || (taken && !same_dev) || (done_dma_acknowledge && method_all)) begin
            next_pending = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= bdp_pkg::ST_READY;
            pending  <= 1'b0;
            cur      <= '0;
            last_dev <= '0;
        end else begin
            state    <= next_state;
            pending  <= next_pending;
            cur      <= taken ? req : cur;
            last_dev <= done_dma_acknowledge ? cur : last_dev;
        end
    end

    bdp_idle_timer u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (load_timer),
        .load_val (idle_len),
        .last     (timer_last)
    );

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    wire mode_sel   = (clock_mode == bdp_pkg::CLK_MODE_2) || (clock_mode == bdp_pkg::CLK_MODE_6);
    wire mode_input = (clock_mode == bdp_pkg::CLK_MODE_7);

    // Gated copy of the bus clock; glitch-free only while the drive bit is steady
    assign secondary_clock_pin_o  = mode_sel && cfg.secondary_clock_drive && clk;
    assign secondary_clock_pin_oe = !mode_input;
    assign mem_pins_oe = !sw_standby || cfg.memory_pins_float_ctrl;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [3:0] idle_run;
    logic [3:0] idle_want;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_run  <= 4'h0;
            idle_want <= 4'h0;
        end else begin
            idle_run  <= idle_active ? idle_run + 4'h1 : 4'h0;
            idle_want <= load_timer ? idle_len : idle_want;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_rsv_one_read: assert property (cfg_rdata[3] == 1'b1)
        else $error("reserved bit 4 not read as one");
    chk_rsv_zero_read: assert property (cfg_rdata[2] == 1'b0)
        else $error("reserved bit 3 not read as zero");
    // Secondary clock pin checks sample at the falling edge, where the gated clock copy is high
    chk_sec_low_drive: assert property (@(negedge clk)
        mode_sel && !cfg.secondary_clock_drive
        |-> secondary_clock_pin_oe && !secondary_clock_pin_o)
        else $error("secondary clock pin not held low");
    chk_sec_clk_drive: assert property (@(negedge clk)
        mode_sel && cfg.secondary_clock_drive |-> secondary_clock_pin_o)
        else $error("secondary clock pin not following the bus clock");
    chk_sec_mode_off: assert property (@(negedge clk)
        !mode_sel |-> !secondary_clock_pin_o)
        else $error("secondary clock active outside modes 2 and 6");
    chk_mode7_float: assert property (clock_mode == bdp_pkg::CLK_MODE_7
        |-> !secondary_clock_pin_oe)
        else $error("secondary clock pin driven in mode 7");
    chk_mem_pin_float: assert property (sw_standby |-> mem_pins_oe == cfg.memory_pins_float_ctrl)
        else $error("memory pin drive wrong in standby");
    chk_mem_pin_active: assert property (!sw_standby |-> mem_pins_oe)
        else $error("memory pins floated outside standby");
    chk_method1_idle: assert property (done_dma_acknowledge && method_all && idle_len != 4'h0
        |=> idle_active)
        else $error("no idle after acknowledged access under method 1");
    chk_method0_no_idle: assert property (done_dma_acknowledge && !method_all
        |=> !idle_active)
        else $error("idle right after acknowledged access under method 0");
    chk_idle_ready_low: assert property (idle_active |-> !req_ready)
        else $error("request taken during inserted idle cycles");
    chk_handover_idle: assert property (handover && !method_all && idle_len != 4'h0
        |-> !req_ready ##1 idle_active)
        else $error("no idle when a new driver follows an acknowledged device");
    chk_same_dev_pass: assert property (in_ready && req_valid && same_dev && !method_all
        |-> req_ready)
        else $error("same acknowledged device delayed");
    chk_idle_length: assert property ($fell(idle_active) |-> idle_run == idle_want)
        else $error("idle run length differs from decoded count");
    chk_reset_values: assert property (@(posedge clk) $rose(rst_n)
        |-> cfg_rdata == bdp_pkg::CFG_RESET)
        else $error("control word wrong after reset");

    cov_method1_idle: cover property (do_idle_m1);
    cov_handover_idle: cover property (do_idle_m0);
    cov_same_dev_back: cover property (taken && pending && same_dev);
    cov_idle_twelve: cover property ($fell(idle_active) && idle_run == 4'hC);
    cov_mode7_float: cover property (mode_input);
endmodule : bdp_ctrl

// ===== verilog/bdp_pkg.sv
// Package: constants and types for the DMA idle and pin drive control block
// ****************************************************************
// What this block does
// - Method 0: idle cycles only when another driver follows an acknowledged device
// - Method 0: no idle between back-to-back accesses by the same acknowledged device
// - Method 1: idle cycles after every acknowledged access, even back-to-back
// - Reserved bit 4 reads as 1; software writes 1
// - Reserved bit 3 reads as 0; software writes 0
// - Secondary clock drive bit: 0 drives low, 1 drives the bus clock
// - Secondary clock drive bit matters only in clock modes 2 and 6
// - Clock mode 7: secondary clock pin floats whatever the drive bit
// - Memory pin bit: 0 floats memory pins in standby, 1 keeps them driven
// - Idle count codes 0..7 give 0,1,2,4,6,8,10,12 idle cycles
// ****************************************************************
package bdp_pkg;

    // ****************************************************************
    // Field positions in the control word (bits 8 down to 1)
    // ****************************************************************
    localparam int unsigned POS_IDLE_CNT_HI = 8;
    localparam int unsigned POS_IDLE_CNT_LO = 6;
    localparam int unsigned POS_IDLE_METHOD = 5;
    localparam int unsigned POS_RSV_ONE     = 4;
    localparam int unsigned POS_RSV_ZERO    = 3;
    localparam int unsigned POS_SEC_DRIVE   = 2;
    localparam int unsigned POS_MEM_CTRL    = 1;

    // ****************************************************************
    // Reset and fixed values
    // ****************************************************************
    localparam logic [2:0] RST_IDLE_CNT    = 3'h0;
    localparam logic       RST_IDLE_METHOD = 1'h0;
    localparam logic       RSV_ONE_VAL     = 1'h1;
    localparam logic       RSV_ZERO_VAL    = 1'h0;
    localparam logic       RST_SEC_DRIVE   = 1'h0;
    localparam logic       RST_MEM_CTRL    = 1'h0;

    // ****************************************************************
    // Clock modes
    // ****************************************************************
    localparam logic [2:0] CLK_MODE_2 = 3'h2;
    localparam logic [2:0] CLK_MODE_6 = 3'h6;
    localparam logic [2:0] CLK_MODE_7 = 3'h7;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [2:0] dma_idle_count;
        logic       dma_idle_insert_method;
        logic       rsv_one;
        logic       rsv_zero;
        logic       secondary_clock_drive;
        logic       memory_pins_float_ctrl;
    } bdp_cfg_t;

    typedef struct packed {
        logic       dma_acknowledge;
        logic [1:0] chan;
    } bdp_req_t;

    typedef enum logic [2:0] {
        ST_READY  = 3'h1,
        ST_ACCESS = 3'h2,
        ST_IDLE   = 3'h4
    } bdp_state_t;

    localparam bdp_cfg_t CFG_RESET = '{
        dma_idle_count:         RST_IDLE_CNT,
        dma_idle_insert_method: RST_IDLE_METHOD,
        rsv_one:                RSV_ONE_VAL,
        rsv_zero:               RSV_ZERO_VAL,
        secondary_clock_drive:  RST_SEC_DRIVE,
        memory_pins_float_ctrl: RST_MEM_CTRL
    };

    // Idle count decode, used by the block and by its checks
    function automatic logic [3:0] bdp_idle_cycles(input logic [2:0] code);
        case (code)
            3'h0:    bdp_idle_cycles = 4'h0;
            3'h1:    bdp_idle_cycles = 4'h1;
            3'h2:    bdp_idle_cycles = 4'h2;
            3'h3:    bdp_idle_cycles = 4'h4;
            3'h4:    bdp_idle_cycles = 4'h6;
            3'h5:    bdp_idle_cycles = 4'h8;
            3'h6:    bdp_idle_cycles = 4'hA;
            default: bdp_idle_cycles = 4'hC;
        endcase
    endfunction : bdp_idle_cycles

endpackage : bdp_pkg

// ===== verilog/bdp_idle_timer.sv
// Down counter that times one run of inserted idle cycles
module bdp_idle_timer (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       load,
    input  wire logic [3:0] load_val,
    output logic            last
);
    logic [3:0] cnt;
    wire  [3:0] next_cnt = load ? load_val : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign last = (cnt == 4'h1);
endmodule : bdp_idle_timer

// ===== testbench/bdp_dev_model.sv
// Far-side device model that ends each taken access after a chosen delay
module bdp_dev_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       req_valid,
    input  wire logic       req_ready,
    input  wire logic [3:0] delay,
    output logic            acc_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // ****************************************************************
    // Access timing
    // ****************************************************************
    // Delay 1 answers promptly; larger delays model a slow device
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt      <= 4'h0;
            acc_done <= 1'h0;
        end else begin
            acc_done <= (cnt == 4'h1);
            if (req_valid && req_ready) cnt <= delay;
            else if (cnt != 4'h0) cnt <= cnt - 4'h1;
        end
    end
endmodule : bdp_dev_model

// ===== testbench/bdp_ctrl_tb.sv
// Self-checking bench for the idle insertion and pin drive control block
module bdp_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 1'h0, rstn, cfg_wr = 1'h0, req_valid = 1'h0;
    logic              sw_standby = 1'h0, req_ready, acc_done, idle_active;
    logic              sec_o, sec_oe, mem_oe;
    logic [7:0]        cfg_wdata = 8'h08, cfg_rdata, wd;
    logic [2:0]        clock_mode = 3'h0;
    logic [3:0]        delay = 4'h1;
    bdp_pkg::bdp_req_t req = '0;
    int                fail_count = 0, compares = 0, seed = 87562, idle_seen = 0, mark = 0;
    int                idle_tab [8] = '{0, 1, 2, 4, 6, 8, 10, 12};

    always #12.5 clk = ~clk;
    always @(negedge clk) if (idle_active === 1'h1) idle_seen++;

    bdp_ctrl u_bdp_ctrl (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .acc_done(acc_done), .idle_active(idle_active), .clock_mode(clock_mode),
        .secondary_clock_pin_o(sec_o), .secondary_clock_pin_oe(sec_oe),
        .sw_standby(sw_standby), .mem_pins_oe(mem_oe));
    bdp_dev_model u_bdp_dev_model (.clk(clk), .rstn(rstn), .req_valid(req_valid),
        .req_ready(req_ready), .delay(delay), .acc_done(acc_done));

    // ****************************************************************
    // Reporting
    // ****************************************************************
    task test_done;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task bad(string m);
        $display("BAD %0t %s", $time, m);
        fail_count++;
    endtask : bad
    task chk_bits(logic [7:0] got, logic [7:0] exp, string m);
        compares++;
        if (got !== exp) bad(m);
    endtask : chk_bits
    task chk_idle(int got, int exp);
        compares++;
        if (got != exp) bad("idle cycle count");
    endtask : chk_idle
    task timeout;
        bad("wait bound used up");
        test_done;
    endtask : timeout

    // ****************************************************************
    // Drivers
    // ****************************************************************
    task do_reset;
        @(posedge clk);
        rstn <= 1'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'h1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_bits(cfg_rdata, 8'h08, "reset value");
    endtask : do_reset
    // Reserved bits go out as 1 and 0, as software must write them
    task wr_cfg(logic [7:0] d);
        @(posedge clk);
        cfg_wr    <= 1'h1;
        cfg_wdata <= (d & 8'hF3) | 8'h08;
        @(posedge clk);
        cfg_wr <= 1'h0;
        @(negedge clk);
        chk_bits(cfg_rdata, {d[7:4], 2'h2, d[1:0]}, "readback");
    endtask : wr_cfg
    task access(logic dk, logic [1:0] ch, int exp);
        int n;
        @(posedge clk);
        req_valid <= 1'h1;
        req       <= '{dma_acknowledge: dk, chan: ch};
        delay     <= 4'(1 + ($unsigned($random(seed)) % 4));
        @(negedge clk);
        for (n = 0; n < 40 && req_ready !== 1'h1; n++) @(negedge clk);
        if (n == 40) timeout;
        @(posedge clk);
        req_valid <= 1'h0;
        chk_idle(idle_seen - mark, exp);
        mark = idle_seen;
        @(negedge clk);
        for (n = 0; n < 40 && acc_done !== 1'h1; n++) @(negedge clk);
        if (n == 40) timeout;
    endtask : access
    // Sequence ends on a plain access so no idle leaks into the next one
    task idle_run(logic method, logic [2:0] code);
        logic       pend, dk;
        logic [1:0] pch, ch;
        pend = 1'h0;
        pch  = 2'h0;
        wr_cfg({code, method, 2'h2, 2'($random(seed))});
        mark = idle_seen;
        for (int k = 0; k < 7; k++) begin
            dk = (k < 6) ? 1'($random(seed)) : 1'h0;
            ch = 2'($random(seed) & 1);
            access(dk, ch, (pend && (method || !(dk && ch == pch))) ? idle_tab[code] : 0);
            pend = dk;
            pch  = ch;
        end
    endtask : idle_run

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        // Reset edge at time 0, so no flop is unknown at the first clock edge
        rstn <= 1'h0;
        do_reset;
        repeat (12) wr_cfg(8'($random(seed)));
        do_reset;
        $display("register test done");
        for (int m = 0; m < 2; m++) for (int c = 0; c < 8; c++) idle_run(1'(m), 3'(c));
        $display("idle insertion test done");
        for (int i = 0; i < 32; i++) begin
            wd = 8'($random(seed));
            wr_cfg(wd);
            @(posedge clk);
            clock_mode <= 3'(i);
            sw_standby <= 1'($random(seed));
            @(posedge clk);
            #2;
            chk_bits({5'h0, sec_oe, sec_o, mem_oe}, {5'h0, clock_mode != 3'h7,
                wd[1] && (clock_mode == 3'h2 || clock_mode == 3'h6),
                !sw_standby || wd[0]}, "pins high phase");
            @(negedge clk);
            chk_bits({5'h0, sec_oe, sec_o, mem_oe}, {5'h0, clock_mode != 3'h7, 1'h0,
                !sw_standby || wd[0]}, "pins low phase");
        end
        $display("pin drive test done");
        test_done;
    end
endmodule : bdp_ctrl_tb
